// File: design/body_timer_alarm_controller.sv
// Purpose: timed body outputs driven from vehicle switches
// Assumes: all switch inputs asynchronous, active high when named state
// Notes: outputs feed the output_driver_stage transistors
// Function
// - ignition on during illumination: lamp off at once, timer ended
// - doors all closed, ignition not on: dome, foot lights fade six seconds
// - ignition on: no fading, lights out immediately
// - defogger press with ignition on: relay eleven minutes, latched
// - second defogger press during interval: timer stopped, relay off
// - ignition on: belt lamp flashes four times within six seconds
// - belt unfastened at ignition on: buzzer intermittent six seconds
// - driver door locked: lock output to all doors half a second
// - unlock by key with driver door unlocked: half second unlock pulse
// - ignition on to off, all closed: window relay thirty seconds
// - any door or liftgate opening ends window interval at once
// - lights on, ignition off, driver door open: continuous buzzer
// - key reminder intermittent pattern wins over light reminder
// - key in, front door open, driver knob locked: unlock five seconds
// - key in, driver locked, passenger open and locked: unlock five seconds
// - key in, ignition not on, driver door open: intermittent buzzer
// - belt fastened or ignition off stops belt buzzer
// - illumination timer ignores driver door changes while running
// - ignition off during defogger interval: timer stopped, relay off
`timescale 1ns/1ps
module body_timer_alarm_controller
  import body_timer_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ignitionOn,
  input wire logic accessory_position,
  input wire logic keyInserted,
  input wire logic driverDoorOpen,
  input wire logic passengerDoorOpen,
  input wire logic rearDoorOpen,
  input wire logic liftgateOpen,
  input wire logic driverLocked,
  input wire logic passengerLocked,
  input wire logic keyCylinderUnlock,
  input wire logic defoggerSwitch,
  input wire logic beltBuckled,
  input wire logic lightsOn,
  output logic illuminationLamp,
  output logic domeLamp,
  output logic defoggerRelay,
  output logic beltLamp,
  output logic buzzer,
  output logic lockDrive,
  output logic unlockDrive,
  output logic windowRelay
);
  localparam int PW = $clog2(TICK_CYCLES);

  if (TICK_CYCLES < 2) begin : badTick
    $error("TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [NIN-1:0] s1, s2, st, sp;
    logic [NIN-1:0][3:0] db;
    logic [PW-1:0] pre;
    logic tick;
    logic [TW-1:0] bz, illum, dim, defog, belt, beltBz, flash;
    logic [TW-1:0] lock, unl, win;
    logic buzzOn;
    logic [3:0] pwm;
    logic illumOut, domeOut, defogOut, beltOut;
    logic buzzerOut, lockOut, unlockOut, windowOut;
  } state_t;

  state_t state_q;
  state_t state_d;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] rise;
  logic [NIN-1:0] fall;
  logic ignOn;
  logic ignOff;
  logic keyIn;
  logic anyOpen;
  logic frontOpen;
  logic closedRise;
  logic keyAlarm;
  logic lightRem;

  function automatic logic [TW-1:0] dec(input logic [TW-1:0] c,
                                        input logic t);
    return (t && c != '0) ? c - 1'b1 : c;
  endfunction

  assign raw = {lightsOn, beltBuckled, defoggerSwitch, keyCylinderUnlock,
                passengerLocked, driverLocked, liftgateOpen, rearDoorOpen,
                passengerDoorOpen, driverDoorOpen, keyInserted,
                accessory_position, ignitionOn};
  assign rise = state_q.st & ~state_q.sp;
  assign fall = ~state_q.st & state_q.sp;
  assign ignOn = state_q.st[I_IGN];
  assign ignOff = !ignOn && !state_q.st[I_ACC];
  assign keyIn = state_q.st[I_KEY];
  assign anyOpen = |(state_q.st & DOOR_MASK);
  assign frontOpen = state_q.st[I_DDR] || state_q.st[I_PDR];
  assign closedRise = !anyOpen && |(state_q.sp & DOOR_MASK);
  assign keyAlarm = keyIn && !ignOn && state_q.st[I_DDR];
  assign lightRem = state_q.st[I_LGT] && ignOff && state_q.st[I_DDR];

  always_comb begin
    state_d = state_q;
    // s1 feeds only s2; everything else sees debounced levels
    state_d.s1 = raw;
    state_d.s2 = state_q.s1;
    state_d.sp = state_q.st;
    state_d.tick = 1'b0;
    if (state_q.pre == PW'(TICK_CYCLES - 1)) begin
      state_d.pre = '0;
      state_d.tick = 1'b1;
    end else begin
      state_d.pre = state_q.pre + 1'b1;
    end
    for (int i = 0; i < NIN; i++) begin
      if (state_q.s2[i] == state_q.st[i]) begin
        state_d.db[i] = '0;
      end else if (state_q.tick) begin
        if (state_q.db[i] == DEB_T - 4'h1) begin
          state_d.st[i] = state_q.s2[i];
          state_d.db[i] = '0;
        end else begin
          state_d.db[i] = state_q.db[i] + 4'h1;
        end
      end
    end
    // illumination
    state_d.illum = dec(state_q.illum, state_q.tick);
    if (rise[I_DDR] && !ignOn && state_q.illum == '0) begin
      state_d.illum = ILLUM_T;
    end
    if (ignOn) begin
      state_d.illum = '0;
    end
    // dome fade; an open door lights the lamp outright
    state_d.dim = dec(state_q.dim, state_q.tick);
    if (closedRise && !ignOn) begin
      state_d.dim = DIM_T;
    end
    if (ignOn || anyOpen) begin
      state_d.dim = '0;
    end
    if (state_q.tick) begin
      state_d.pwm = state_q.pwm + 4'h1;
    end
    // defogger
    state_d.defog = dec(state_q.defog, state_q.tick);
    if (rise[I_DEF]) begin
      if (state_q.defog != '0) begin
        state_d.defog = '0;
      end else if (ignOn) begin
        state_d.defog = DEFOG_T;
      end
    end
    if (!ignOn) begin
      state_d.defog = '0;
    end
    // seat belt lamp and buzzer
    state_d.belt = dec(state_q.belt, state_q.tick);
    state_d.beltBz = dec(state_q.beltBz, state_q.tick);
    if (state_q.tick) begin
      if (state_q.flash == FLASH_PER - 1'b1) begin
        state_d.flash = '0;
      end else begin
        state_d.flash = state_q.flash + 1'b1;
      end
    end
    if (rise[I_IGN]) begin
      state_d.belt = BELT_T;
      state_d.flash = '0;
      if (!state_q.st[I_BLT]) begin
        state_d.beltBz = BELT_T;
      end
    end
    if (!ignOn) begin
      state_d.belt = '0;
      state_d.beltBz = '0;
    end
    if (state_q.st[I_BLT]) begin
      state_d.beltBz = '0;
    end
    // door locks; key release beats central lock
    state_d.lock = dec(state_q.lock, state_q.tick);
    state_d.unl = dec(state_q.unl, state_q.tick);
    if (rise[I_DLK]) begin
      if (keyIn && frontOpen) begin
        state_d.unl = KEYREL_T;
      end else if (!keyIn || !anyOpen) begin
        state_d.lock = PULSE_T;
      end
    end
    if (rise[I_PLK] && keyIn && state_q.st[I_DLK]
        && state_q.st[I_PDR]) begin
      state_d.unl = KEYREL_T;
    end
    if (rise[I_KCU] && !state_q.st[I_DLK] && state_q.unl == '0) begin
      state_d.unl = PULSE_T;
    end
    // never drive both actuator directions together
    if (state_d.unl != '0) begin
      state_d.lock = '0;
    end
    // power window
    state_d.win = dec(state_q.win, state_q.tick);
    if (fall[I_IGN] && !anyOpen) begin
      state_d.win = WINDOW_T;
    end
    if (anyOpen || ignOn) begin
      state_d.win = '0;
    end
    // shared intermittent buzzer phase
    if (state_q.tick) begin
      if (state_q.bz == BUZZ_T - 1'b1) begin
        state_d.bz = '0;
        state_d.buzzOn = !state_q.buzzOn;
      end else begin
        state_d.bz = state_q.bz + 1'b1;
      end
    end
    // 16 step pwm caps the first fade level below full brightness
    state_d.illumOut = state_d.illum != '0;
    state_d.domeOut = anyOpen || (state_d.dim != '0
                      && state_q.pwm < state_d.dim[DIM_SH+:4]);
    state_d.defogOut = state_d.defog != '0;
    state_d.beltOut = state_d.belt != '0 && state_d.flash < FLASH_ON;
    if (keyAlarm || state_q.beltBz != '0) begin
      state_d.buzzerOut = state_q.buzzOn;
    end else begin
      state_d.buzzerOut = lightRem;
    end
    state_d.lockOut = state_d.lock != '0;
    state_d.unlockOut = state_d.unl != '0;
    state_d.windowOut = ignOn || state_d.win != '0;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign illuminationLamp = state_q.illumOut;
  assign domeLamp = state_q.domeOut;
  assign defoggerRelay = state_q.defogOut;
  assign beltLamp = state_q.beltOut;
  assign buzzer = state_q.buzzerOut;
  assign lockDrive = state_q.lockOut;
  assign unlockDrive = state_q.unlockOut;
  assign windowRelay = state_q.windowOut;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  illum_start_a: assert property (
    rise[I_DDR] && !ignOn && state_q.illum == '0
    |=> state_q.illum == ILLUM_T && state_q.illumOut)
    else $error("illumination did not start");
  illum_ign_off_a: assert property (
    ignOn |=> !state_q.illumOut && state_q.illum == '0)
    else $error("illumination stayed on with ignition on");
  illum_no_restart_a: assert property (
    state_q.illum != '0 |=> state_q.illum <= $past(state_q.illum))
    else $error("illumination timer restarted");
  dim_start_a: assert property (
    closedRise && !ignOn |=> state_q.dim == DIM_T)
    else $error("dome fade did not start");
  dim_ign_cut_a: assert property (
    ignOn && !anyOpen |=> !state_q.domeOut && state_q.dim == '0)
    else $error("dome lamp lit with ignition on");
  defog_start_a: assert property (
    rise[I_DEF] && state_q.defog == '0 && ignOn
    |=> state_q.defog == DEFOG_T && state_q.defogOut)
    else $error("defogger did not start");
  defog_cancel_a: assert property (
    rise[I_DEF] && state_q.defog != '0 |=> !state_q.defogOut)
    else $error("second press did not stop defogger");
  defog_ign_off_a: assert property (
    !ignOn |=> !state_q.defogOut)
    else $error("defogger on without ignition");
  belt_flash_a: assert property (
    rise[I_IGN] ##1 ignOn |=> state_q.beltOut
    && state_q.belt == BELT_T - $past(state_q.tick, 1))
    else $error("belt lamp flash did not begin");
  belt_buzz_start_a: assert property (
    rise[I_IGN] && !state_q.st[I_BLT] |=> state_q.beltBz == BELT_T)
    else $error("belt buzzer interval not started");
  belt_buzz_stop_a: assert property (
    state_q.beltBz != '0 && (state_q.st[I_BLT] || !ignOn)
    |=> state_q.beltBz == '0)
    else $error("belt buzzer not stopped");
  lock_pulse_a: assert property (
    rise[I_DLK] && !(keyIn && frontOpen) && (!keyIn || !anyOpen)
    && state_d.unl == '0
    |=> state_q.lock == PULSE_T && state_q.lockOut)
    else $error("lock pulse missing");
  key_release_a: assert property (
    rise[I_DLK] && keyIn && frontOpen
    |=> state_q.unl == KEYREL_T && !state_q.lockOut)
    else $error("key reminder release missing");
  unlock_pulse_a: assert property (
    rise[I_KCU] && !state_q.st[I_DLK] && state_q.unl == '0
    |=> state_q.unl == PULSE_T && state_q.unlockOut)
    else $error("unlock pulse missing");
  window_start_a: assert property (
    fall[I_IGN] && !anyOpen |=> state_q.win == WINDOW_T
    && state_q.windowOut)
    else $error("window interval not started");
  window_cut_a: assert property (
    anyOpen && !ignOn |=> !state_q.windowOut)
    else $error("window relay on with a door open");
  buzz_priority_a: assert property (
    keyAlarm |=> state_q.buzzerOut == $past(state_q.buzzOn))
    else $error("key reminder pattern lost priority");
  light_remind_a: assert property (
    lightRem && !keyAlarm && state_q.beltBz == '0 |=> state_q.buzzerOut)
    else $error("light reminder silent");
  debounce_tick_a: assert property (
    !state_q.tick |=> $stable(state_q.st))
    else $error("debounced input moved off tick");
endmodule // body_timer_alarm_controller

// File: design/body_timer_pkg.sv
// Purpose: shared constants of the body timer and alarm controller
// Assumes: 100 MHz clock, 1 ms timebase tick
// Notes: every interval is counted in ticks
package body_timer_pkg;
  localparam int CLK_MHZ = 100;
  localparam int TICK_MS = 1;
  localparam int US_PER_MS = 1000;
  localparam int TICK_CYC = TICK_MS * US_PER_MS * CLK_MHZ;
  localparam int TW = 20;
  localparam int MS_PER_S = 1000;
  localparam int SEC_PER_MIN = 60;
  localparam int ILLUM_S = 10;
  localparam int DIM_S = 6;
  localparam int DEFOG_MIN = 11;
  localparam int BELT_S = 6;
  localparam int BELT_FLASHES = 4;
  localparam int PULSE_MS = 500;
  localparam int KEYREL_S = 5;
  localparam int WINDOW_S = 30;
  localparam int BUZZ_HALF_MS = 250;
  localparam int DEBOUNCE_MS = 10;
  localparam int DIM_SH = 9;
  localparam logic [TW-1:0] ILLUM_T = TW'(ILLUM_S * MS_PER_S / TICK_MS);
  localparam logic [TW-1:0] DIM_T = TW'(DIM_S * MS_PER_S / TICK_MS);
  localparam logic [TW-1:0] DEFOG_T =
    TW'(DEFOG_MIN * SEC_PER_MIN * MS_PER_S / TICK_MS);
  localparam logic [TW-1:0] BELT_T = TW'(BELT_S * MS_PER_S / TICK_MS);
  localparam logic [TW-1:0] FLASH_PER = TW'(BELT_S * MS_PER_S / TICK_MS
    / BELT_FLASHES);
  localparam logic [TW-1:0] FLASH_ON = FLASH_PER >> 1;
  localparam logic [TW-1:0] PULSE_T = TW'(PULSE_MS / TICK_MS);
  localparam logic [TW-1:0] KEYREL_T = TW'(KEYREL_S * MS_PER_S / TICK_MS);
  localparam logic [TW-1:0] WINDOW_T = TW'(WINDOW_S * MS_PER_S / TICK_MS);
  localparam logic [TW-1:0] BUZZ_T = TW'(BUZZ_HALF_MS / TICK_MS);
  localparam logic [3:0] DEB_T = 4'(DEBOUNCE_MS / TICK_MS);
  localparam int NIN = 13;
  localparam int I_IGN = 0;
  localparam int I_ACC = 1;
  localparam int I_KEY = 2;
  localparam int I_DDR = 3;
  localparam int I_PDR = 4;
  localparam int I_RDR = 5;
  localparam int I_LFT = 6;
  localparam int I_DLK = 7;
  localparam int I_PLK = 8;
  localparam int I_KCU = 9;
  localparam int I_DEF = 10;
  localparam int I_BLT = 11;
  localparam int I_LGT = 12;
  localparam logic [NIN-1:0] DOOR_MASK = 13'h0078;
endpackage

// File: bench/vehicle_switches.sv
// Purpose: switch bank and lock actuators around the controller
// Assumes: bench sets wanted switch levels on cmd
// Notes: lock state follows knob edges, then the lock drives
`timescale 1ns/1ps
module vehicle_switches
  import body_timer_pkg::*;
(
  input wire logic clock,
  input wire logic [NIN-1:0] cmd,
  input wire logic lockDrive,
  input wire logic unlockDrive,
  output logic [NIN-1:0] pins
);
  logic [1:0] lockState_q = 2'h0;
  logic [1:0] knob_q = 2'h0;
  logic [1:0] knob;
  assign knob = {cmd[I_PLK], cmd[I_DLK]};
  // a knob move wins over an actuator stroke in the same cycle
  always @(posedge clock) begin
    knob_q <= knob;
    for (int i = 0; i < 2; i++) begin
      if (knob[i] != knob_q[i]) begin
        lockState_q[i] <= knob[i];
      end else if (unlockDrive) begin
        lockState_q[i] <= 1'b0;
      end else if (lockDrive) begin
        lockState_q[i] <= 1'b1;
      end
    end
  end
  always_comb begin
    pins = cmd;
    pins[I_DLK] = lockState_q[0];
    pins[I_PLK] = lockState_q[1];
  end
endmodule // vehicle_switches

// File: bench/tb_body_timer_alarm_controller.sv
// Purpose: self-checking bench of the body timer controller
// Assumes: tick shortened to two cycles, intervals scale with it
// Notes: the 11 min and 30 s intervals are only started and cut short
`timescale 1ns/1ps
module tb_body_timer_alarm_controller
  import body_timer_pkg::*;
;
  localparam int TC = 2;
  localparam int SETTLE = (int'(DEB_T) + 2) * TC + 8;
  localparam int DW = 1200;
  localparam int O_ILL = 0;
  localparam int O_DOM = 1;
  localparam int O_DEF = 2;
  localparam int O_BLT = 3;
  localparam int O_BUZ = 4;
  localparam int O_LCK = 5;
  localparam int O_UNL = 6;
  localparam int O_WIN = 7;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [NIN-1:0] cmd = '0;
  logic [NIN-1:0] pins;
  wire logic [7:0] outs;
  int errTotal = 0;
  int comparisons = 0;
  int beltRises = 0;
  int cyc = 0;
  int t0;
  int presses;
  int n;
  initial begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock) cyc++;
  always @(posedge outs[O_BLT]) beltRises++;
  vehicle_switches u_sw (.clock(clock), .cmd(cmd),
    .lockDrive(outs[O_LCK]), .unlockDrive(outs[O_UNL]), .pins(pins));
  body_timer_alarm_controller #(.TICK_CYCLES(TC)) u_dut (
    .clock(clock), .resetn(resetn),
    .ignitionOn(pins[I_IGN]), .accessory_position(pins[I_ACC]),
    .keyInserted(pins[I_KEY]), .driverDoorOpen(pins[I_DDR]),
    .passengerDoorOpen(pins[I_PDR]), .rearDoorOpen(pins[I_RDR]),
    .liftgateOpen(pins[I_LFT]), .driverLocked(pins[I_DLK]),
    .passengerLocked(pins[I_PLK]), .keyCylinderUnlock(pins[I_KCU]),
    .defoggerSwitch(pins[I_DEF]), .beltBuckled(pins[I_BLT]),
    .lightsOn(pins[I_LGT]), .illuminationLamp(outs[O_ILL]),
    .domeLamp(outs[O_DOM]), .defoggerRelay(outs[O_DEF]),
    .beltLamp(outs[O_BLT]), .buzzer(outs[O_BUZ]),
    .lockDrive(outs[O_LCK]), .unlockDrive(outs[O_UNL]),
    .windowRelay(outs[O_WIN]));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check_bit(string name, logic exp, logic got);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic check_count(string name, int exp, int got, int tol);
    comparisons++;
    if (got < exp - tol || got > exp + tol) begin
      errTotal++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic poke(int idx, logic v);
    @(posedge clock);
    #1 cmd[idx] = v;
  endtask
  // waits past sync and debounce so outputs have settled
  task automatic put(int idx, logic v);
    poke(idx, v);
    repeat (SETTLE) @(posedge clock);
    #2;
  endtask
  task automatic wait_level(int sel, logic lvl, int bound, output int k);
    k = 0;
    while (outs[sel] !== lvl) begin
      if (k == bound) begin
        check_bit("output wait", lvl, outs[sel]);
        summarize();
      end
      @(posedge clock);
      #2;
      k++;
    end
  endtask
  task automatic pulse(string name, int sel, int ticks);
    int k;
    wait_level(sel, 1'b1, 4 * SETTLE, k);
    wait_level(sel, 1'b0, 2 * TC * ticks, k);
    check_count(name, ticks, k / TC, 2);
  endtask
  task automatic duty(string name, int sel, int pct, int tol);
    int hi;
    hi = 0;
    repeat (DW) begin
      @(posedge clock);
      #2;
      if (outs[sel] === 1'b1) hi++;
    end
    check_count(name, pct, hi * 100 / DW, tol);
  endtask
  // first fade level of a 16 step pwm, in percent
  function automatic int fade_pct();
    return int'(DIM_T >> DIM_SH) * 100 / 16;
  endfunction
  initial begin
    void'($urandom(32'hda76));
    repeat (2) @(posedge clock);
    #1 resetn = 1'b1;
    repeat (10) @(posedge clock);
    #2;
    for (int i = 0; i < 8; i++) begin
      check_bit("output idle", 1'b0, outs[i]);
    end
    poke(I_DLK, 1'b1);
    pulse("lock pulse", O_LCK, int'(PULSE_T));
    put(I_DLK, 1'b0);
    poke(I_KCU, 1'b1);
    pulse("unlock pulse", O_UNL, int'(PULSE_T));
    put(I_KCU, 1'b0);
    put(I_KEY, 1'b1);
    t0 = cyc;
    put(I_DDR, 1'b1);
    check_bit("illumination", 1'b1, outs[O_ILL]);
    duty("key alarm duty", O_BUZ, 50, 25);
    put(I_LGT, 1'b1);
    duty("key over light duty", O_BUZ, 50, 25);
    put(I_DDR, 1'b0);
    put(I_DDR, 1'b1);
    poke(I_DLK, 1'b1);
    pulse("key release", O_UNL, int'(KEYREL_T));
    put(I_DLK, 1'b0);
    put(I_KEY, 1'b0);
    duty("light reminder duty", O_BUZ, 100, 0);
    put(I_LGT, 1'b0);
    wait_level(O_ILL, 1'b0, 2 * TC * int'(ILLUM_T), n);
    n = (cyc - t0) / TC;
    check_count("illumination ticks", int'(ILLUM_T), n, 30);
    put(I_DDR, 1'b0);
    put(I_DDR, 1'b1);
    beltRises = 0;
    put(I_IGN, 1'b1);
    check_bit("illumination cut", 1'b0, outs[O_ILL]);
    check_bit("window with ignition", 1'b1, outs[O_WIN]);
    duty("belt buzzer duty", O_BUZ, 50, 25);
    put(I_BLT, 1'b1);
    check_bit("belt buzzer stop", 1'b0, outs[O_BUZ]);
    // odd press counts leave the relay on, even ones off
    presses = 0;
    repeat (4) begin
      n = $urandom_range(3, 1);
      presses += n;
      repeat (n) begin
        put(I_DEF, 1'b1);
        put(I_DEF, 1'b0);
      end
      check_bit("defogger relay", presses[0], outs[O_DEF]);
    end
    if (presses[0] == 1'b0) put(I_DEF, 1'b1);
    put(I_DEF, 1'b0);
    repeat (TC * int'(BELT_T)) @(posedge clock);
    check_count("belt flashes", BELT_FLASHES, beltRises, 0);
    // a one cycle bounce must not reach the defogger toggle
    poke(I_DEF, 1'b1);
    put(I_DEF, 1'b0);
    check_bit("defogger glitch", 1'b1, outs[O_DEF]);
    check_bit("defogger running", 1'b1, outs[O_DEF]);
    put(I_IGN, 1'b0);
    check_bit("defogger off", 1'b0, outs[O_DEF]);
    put(I_DDR, 1'b0);
    put(I_KEY, 1'b1);
    poke(I_DLK, 1'b1);
    pulse("lock with key, closed", O_LCK, int'(PULSE_T));
    put(I_PLK, 1'b1);
    put(I_PLK, 1'b0);
    put(I_PDR, 1'b1);
    poke(I_PLK, 1'b1);
    pulse("passenger key release", O_UNL, int'(KEYREL_T));
    put(I_PDR, 1'b0);
    put(I_KEY, 1'b0);
    put(I_IGN, 1'b1);
    put(I_IGN, 1'b0);
    check_bit("window hold", 1'b1, outs[O_WIN]);
    put(I_RDR, 1'b1);
    check_bit("window cut", 1'b0, outs[O_WIN]);
    check_bit("dome with door", 1'b1, outs[O_DOM]);
    put(I_RDR, 1'b0);
    duty("dome fade duty", O_DOM, fade_pct(), 10);
    put(I_IGN, 1'b1);
    check_bit("dome out", 1'b0, outs[O_DOM]);
    summarize();
  end
endmodule // tb_body_timer_alarm_controller
